//--- core/strap_latch_and_pin_function_mux.sv
// Strap capture, strap decode and per-pin function selection with override.
// Assumes strap inputs are synchronous and already resolved to level codes.
`timescale 1ns/1ps
`include "strap_mux_consts.svh"
module strap_latch_and_pin_function_mux
  import strap_mux_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chip_reset_n,
  // Strap levels
  input wire logic [5:0] port_plus_line_disable_strap,
  input wire logic [5:0] port_minus_line_disable_strap,
  input wire logic [2:0] fixed_port_count_strap,
  input wire logic [2:0] charging_port_count_strap,
  input wire logic [2:0] map_strap_1,
  input wire logic [2:0] map_strap_2,
  // Pin mux override port
  input wire logic ovr_wr,
  input wire logic [1:0] ovr_src,
  input wire logic [4:0] ovr_pin,
  input wire logic [5:0] ovr_func,
  input wire logic enumerated,
  // Decoded configuration
  output logic straps_valid,
  output logic [5:0] plus_line_disabled,
  output logic [5:0] minus_line_disabled,
  output logic [5:0] port_disabled,
  output logic [5:0] superspeed_disabled,
  output logic [5:0] port_fixed,
  output logic [5:0] dcp_enable,
  output logic [5:0] cdp_enable,
  output logic map_config_two,
  output logic map_reserved,
  output logic ovr_rejected,
  output logic [28*6+5:0] pin_func
);

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic in_reset;
  logic [5:0] cap_plus;
  logic [5:0] cap_minus;
  logic [2:0] cap_fixed;
  logic [2:0] cap_chg;
  logic [2:0] cap_map1;
  logic [2:0] cap_map2;
  logic next_latched;
  logic latched;

  // External reset counts as reset just like power-on
  assign in_reset = !chip_reset_n;

  // track while reset
  // Captures follow the straps every cycle while reset is held, freeze after release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cap_plus <= 6'h00;
      cap_minus <= 6'h00;
      cap_fixed <= `LVL_WEAK_DOWN;
      cap_chg <= `LVL_WEAK_DOWN;
      cap_map1 <= `LVL_WEAK_DOWN;
      cap_map2 <= `LVL_WEAK_DOWN;
    end
    else if (in_reset || !latched)
    begin
      cap_plus <= port_plus_line_disable_strap;
      cap_minus <= port_minus_line_disable_strap;
      cap_fixed <= fixed_port_count_strap;
      cap_chg <= charging_port_count_strap;
      cap_map1 <= map_strap_1;
      cap_map2 <= map_strap_2;
    end
  end

  // Latched goes high on the same edge as the first capture outside reset
  assign next_latched = !in_reset;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      latched <= 1'b0;
    else
      latched <= next_latched;
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Level code to low-first port mask; unknown codes read as no ports
  function automatic logic [5:0] level_mask(input logic [2:0] lvl);
    case (lvl)
      `LVL_WEAK_DOWN: level_mask = `MASK_L0;
      `LVL_WEAK_UP: level_mask = `MASK_L1;
      `LVL_MED_DOWN: level_mask = `MASK_L2;
      `LVL_MED_UP: level_mask = `MASK_L3;
      `LVL_STRONG_DOWN: level_mask = `MASK_L4;
      `LVL_STRONG_UP: level_mask = `MASK_L5;
      default: level_mask = `MASK_L0;
    endcase
  endfunction : level_mask

  logic [5:0] next_port_disabled;
  logic [5:0] chg_mask;
  fmap_e next_map;

  assign next_port_disabled = cap_plus & cap_minus;
  assign chg_mask = level_mask(cap_chg);

  // Reserved combinations fall back to configuration one for pin defaults
  always_comb
  begin
    next_map = MAP_RESERVED;
    if (cap_map2 == `LVL_WEAK_DOWN && cap_map1 == `LVL_WEAK_DOWN)
      next_map = MAP_CONFIG_ONE;
    else if (cap_map2 == `LVL_WEAK_DOWN && cap_map1 == `LVL_WEAK_UP)
      next_map = MAP_CONFIG_TWO;
  end

  // Outputs follow the captures every cycle, also while straps are live; straps_valid marks them frozen
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      straps_valid <= 1'b0;
      plus_line_disabled <= 6'h00;
      minus_line_disabled <= 6'h00;
      port_disabled <= 6'h00;
      superspeed_disabled <= 6'h00;
      port_fixed <= 6'h00;
      dcp_enable <= 6'h00;
      cdp_enable <= 6'h00;
      map_config_two <= 1'b0;
      map_reserved <= 1'b0;
    end
    else
    begin
      straps_valid <= latched;
      plus_line_disabled <= cap_plus;
      minus_line_disabled <= cap_minus;
      port_disabled <= next_port_disabled;
      superspeed_disabled <= next_port_disabled;
      port_fixed <= level_mask(cap_fixed);
      dcp_enable <= chg_mask;
      cdp_enable <= chg_mask;
      map_config_two <= (next_map == MAP_CONFIG_TWO);
      map_reserved <= (next_map == MAP_RESERVED);
    end
  end

  // ----------------------------------------
  // Pin function table
  // ----------------------------------------
  // Default function for a pin index 3..31 under the chosen map
  function automatic logic [5:0] pin_default(input int pin, input logic two);
    logic [5:0] f;
    f = `FN_NONE;
    case (pin)
      3: f = `FN_CONN_SUPPLY_SWITCH_B;
      4: f = `FN_CONN_SUPPLY_SWITCH_A;
      5: f = `FN_PORT_DISCHARGE_CONTROL;
      6: f = `FN_GENERAL_IO_70;
      7: f = two ? `FN_MICROPHONE_DETECT : `FN_GENERAL_IO_71;
      8: f = `FN_GENERAL_IO_72;
      9: f = `FN_GENERAL_IO_73;
      10: f = two ? `FN_AUDIO_SERIAL_IN : `FN_PORT2_POWER_CTL_SUPERSPEED;
      11: f = two ? `FN_AUDIO_MASTER_CLOCK : `FN_PORT3_POWER_CTL_SUPERSPEED;
      12: f = `FN_PORT4_POWER_CTL_SUPERSPEED;
      13: f = `FN_PORT4_POWER_CTL;
      14: f = `FN_PORT3_POWER_CTL;
      15: f = `FN_PORT2_POWER_CTL;
      16: f = `FN_PORT5_POWER_CTL;
      17: f = `FN_PORT1_POWER_CTL;
      18: f = `FN_ALERT_INPUT_ZERO;
      19: f = two ? `FN_AUDIO_SERIAL_OUT : `FN_NONE;
      20: f = `FN_FLASH_SELECT_N;
      21: f = `FN_FLASH_CLOCK;
      22: f = `FN_FLASH_DATA0;
      23: f = `FN_FLASH_DATA1;
      24: f = `FN_FLASH_DATA2;
      25: f = `FN_FLASH_DATA3;
      26: f = two ? `FN_AUDIO_BIT_CLOCK : `FN_TWOWIRE_TARGET_CLOCK;
      27: f = two ? `FN_PORT6_POWER_CTL : `FN_TWOWIRE_TARGET_DATA;
      28: f = two ? `FN_AUDIO_WORD_SELECT : `FN_PORT6_POWER_CTL;
      29: f = `FN_NONE;
      30: f = `FN_TWOWIRE_BRIDGE_CLOCK;
      31: f = `FN_TWOWIRE_BRIDGE_DATA;
      default: f = `FN_NONE;
    endcase
    pin_default = f;
  endfunction : pin_default

  // ----------------------------------------
  // Override acceptance
  // ----------------------------------------
  logic src_ok;
  logic pin_ok;
  logic ovr_accept;

  // source gating
  // Runtime writes only count once the hub has enumerated
  always_comb
  begin
    case (ovr_src_e'(ovr_src))
      OVR_CONFIG_STAGE: src_ok = 1'b1;
      OVR_OTP: src_ok = 1'b1;
      OVR_RUNTIME: src_ok = enumerated;
      default: src_ok = 1'b0;
    endcase
  end

  assign pin_ok = (ovr_pin >= 5'(`PIN_FIRST)) && (ovr_pin <= 5'(`PIN_LAST));
  // Writes before straps freeze are dropped; defaults would overwrite them anyway
  assign ovr_accept = ovr_wr && src_ok && pin_ok && latched;

  // Flags a rejected write for one cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ovr_rejected <= 1'b0;
    else
      ovr_rejected <= ovr_wr && !ovr_accept;
  end

  // ----------------------------------------
  // Per-pin function registers
  // ----------------------------------------
  logic map_two_sel;
  assign map_two_sel = (next_map == MAP_CONFIG_TWO);

  genvar gp;
  generate
    for (gp = `PIN_FIRST; gp <= `PIN_LAST; gp++)
    begin : g_pin
      // Defaults reload while straps are live; overrides win afterwards
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          pin_func[(gp-`PIN_FIRST)*6 +: 6] <= `FN_NONE;
        else if (!latched)
          pin_func[(gp-`PIN_FIRST)*6 +: 6] <= pin_default(gp, map_two_sel);
        else if (ovr_accept && ovr_pin == 5'(gp))
          pin_func[(gp-`PIN_FIRST)*6 +: 6] <= ovr_func;
      end
    end
  endgenerate

endmodule : strap_latch_and_pin_function_mux

//--- core/strap_mux_consts.svh
// Constants for the strap latch and programmable pin function mux.
// Assumes strap levels are already resolved to codes by the analog front end.
// Behaviour
// - Sample straps during reset, hold after release
// - Plus-line strap high means D+ disabled
// - Minus-line strap high means D- disabled
// - Port disabled only when both straps high
// - Disabled USB 2.0 port disables USB 3.0
// - Fixed-port strap level decodes to 0,1,2,3,4,6
// - Fixed ports marked lowest-numbered first
// - Charging strap level decodes to 0,1,2,3,4,6
// - Charging ports get both DCP and CDP
// - 29 pins 3..31 default from map strap
// - Map strap codes select configuration one or two
// - Shared defaults for pins 3-5, 18, 20-25, 30-31
// - Configuration one specific pin defaults
// - Pin 29 has no default function
// - Mux writes override strap default function
// - Overrides accepted in config stage and OTP
// - Overrides accepted at runtime after enumeration
`ifndef STRAP_MUX_CONSTS_SVH
`define STRAP_MUX_CONSTS_SVH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define NUM_PORTS 6
`define PIN_FIRST 3
`define PIN_LAST 31
`define FUNC_W 6
// ----------------------------------------
// Resistor level codes (ascending)
// ----------------------------------------
`define LVL_WEAK_DOWN 3'h0
`define LVL_WEAK_UP 3'h1
`define LVL_MED_DOWN 3'h2
`define LVL_MED_UP 3'h3
`define LVL_STRONG_DOWN 3'h4
`define LVL_STRONG_UP 3'h5
// ----------------------------------------
// Port masks per level
// ----------------------------------------
`define MASK_L0 6'h00
`define MASK_L1 6'h01
`define MASK_L2 6'h03
`define MASK_L3 6'h07
`define MASK_L4 6'h0F
`define MASK_L5 6'h3F
// ----------------------------------------
// Function codes
// ----------------------------------------
`define FN_NONE 6'h00
`define FN_CONN_SUPPLY_SWITCH_B 6'h01
`define FN_CONN_SUPPLY_SWITCH_A 6'h02
`define FN_PORT_DISCHARGE_CONTROL 6'h03
`define FN_GENERAL_IO_70 6'h04
`define FN_GENERAL_IO_71 6'h05
`define FN_GENERAL_IO_72 6'h06
`define FN_GENERAL_IO_73 6'h07
`define FN_PORT2_POWER_CTL_SUPERSPEED 6'h08
`define FN_PORT3_POWER_CTL_SUPERSPEED 6'h09
`define FN_PORT4_POWER_CTL_SUPERSPEED 6'h0A
`define FN_PORT4_POWER_CTL 6'h0B
`define FN_PORT3_POWER_CTL 6'h0C
`define FN_PORT2_POWER_CTL 6'h0D
`define FN_PORT5_POWER_CTL 6'h0E
`define FN_PORT1_POWER_CTL 6'h0F
`define FN_ALERT_INPUT_ZERO 6'h10
`define FN_FLASH_SELECT_N 6'h11
`define FN_FLASH_CLOCK 6'h12
`define FN_FLASH_DATA0 6'h13
`define FN_FLASH_DATA1 6'h14
`define FN_FLASH_DATA2 6'h15
`define FN_FLASH_DATA3 6'h16
`define FN_TWOWIRE_TARGET_CLOCK 6'h17
`define FN_TWOWIRE_TARGET_DATA 6'h18
`define FN_PORT6_POWER_CTL 6'h19
`define FN_TWOWIRE_BRIDGE_CLOCK 6'h1A
`define FN_TWOWIRE_BRIDGE_DATA 6'h1B
`define FN_MICROPHONE_DETECT 6'h1C
`define FN_AUDIO_SERIAL_IN 6'h1D
`define FN_AUDIO_MASTER_CLOCK 6'h1E
`define FN_AUDIO_SERIAL_OUT 6'h1F
`define FN_AUDIO_BIT_CLOCK 6'h20
`define FN_AUDIO_WORD_SELECT 6'h21
`endif

//--- core/strap_mux_pkg.sv
// Types for the strap latch and pin function mux.
// Assumes the constants header is on the include path.
package strap_mux_pkg;
  typedef enum logic [1:0] {MAP_CONFIG_ONE, MAP_CONFIG_TWO, MAP_RESERVED} fmap_e;
  typedef enum logic [1:0] {OVR_NONE, OVR_CONFIG_STAGE, OVR_OTP, OVR_RUNTIME} ovr_src_e;
endpackage : strap_mux_pkg

//--- sim/strap_board.sv
// Board strap resistor model for the strap latch.
// Assumes the bench sets levels that are steady before each strap latching point.
`timescale 1ns/1ps
`include "strap_mux_consts.svh"
module strap_board (
  // Board setup
  input wire logic cfg_two,
  input wire logic [2:0] fixed_lvl,
  input wire logic [2:0] chg_lvl,
  // Strap levels
  output logic [2:0] map_strap_1,
  output logic [2:0] map_strap_2,
  output logic [2:0] map_strap_3,
  output logic [2:0] fixed_port_count_strap,
  output logic [2:0] charging_port_count_strap
);
  assign map_strap_1 = cfg_two ? `LVL_WEAK_UP : `LVL_WEAK_DOWN;
  assign map_strap_2 = `LVL_WEAK_DOWN;
  assign map_strap_3 = `LVL_WEAK_DOWN;
  assign fixed_port_count_strap = fixed_lvl;
  assign charging_port_count_strap = chg_lvl;
endmodule : strap_board

//--- sim/strap_mux_monitor.sv
// Checker for the strap latch and pin mux outputs.
// Assumes it is bound to the top module.
`timescale 1ns/1ps
module strap_mux_monitor (
  // Clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chip_reset_n,
  // Override port
  input wire logic ovr_wr,
  input wire logic [1:0] ovr_src,
  input wire logic [4:0] ovr_pin,
  input wire logic [5:0] ovr_func,
  input wire logic enumerated,
  // Straps
  input wire logic [5:0] port_plus_line_disable_strap,
  input wire logic [5:0] port_minus_line_disable_strap,
  // Decoded outputs
  input wire logic straps_valid,
  input wire logic ovr_rejected,
  input wire logic [5:0] plus_line_disabled,
  input wire logic [5:0] minus_line_disabled,
  input wire logic [5:0] port_disabled,
  input wire logic [5:0] superspeed_disabled,
  input wire logic [5:0] port_fixed,
  input wire logic [5:0] dcp_enable,
  input wire logic [5:0] cdp_enable,
  input wire logic [28*6+5:0] pin_func
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Chip reset pulse ending
  sequence release_s;
    !chip_reset_n ##1 chip_reset_n;
  endsequence
  // Steady run, no reset seen lately
  sequence settled_s;
    chip_reset_n && $past(chip_reset_n) && $past(chip_reset_n, 2) && $past(chip_reset_n, 3);
  endsequence
  latch_release_a:
    assert property (release_s |-> ##[1:2] straps_valid) else $error("straps not latched");
  straps_frozen_a:
    assert property (settled_s ##0 $past(straps_valid) |-> $stable(plus_line_disabled) && $stable(port_fixed))
    else $error("latched straps moved");
  strap_capture_a:
    assert property ($rose(straps_valid) |-> plus_line_disabled == $past(port_plus_line_disable_strap, 2)
      && minus_line_disabled == $past(port_minus_line_disable_strap, 2)) else $error("strap capture wrong");
  both_straps_a:
    assert property (straps_valid |-> port_disabled == (plus_line_disabled & minus_line_disabled))
    else $error("port disable wrong");
  superspeed_follow_a:
    assert property (straps_valid |-> superspeed_disabled == port_disabled) else $error("superspeed mismatch");
  fixed_mask_a:
    assert property (straps_valid |-> (port_fixed & (port_fixed + 6'h01)) == 6'h00 && port_fixed != 6'h1F)
    else $error("fixed mask shape");
  charge_mask_a:
    assert property (straps_valid |-> dcp_enable == cdp_enable && (dcp_enable & (dcp_enable + 6'h01)) == 6'h00
      && dcp_enable != 6'h1F) else $error("charging mask wrong");
  take_override_a:
    assert property (ovr_wr && straps_valid && chip_reset_n && $past(chip_reset_n) && ovr_pin >= 5'h03 &&
      (ovr_src inside {2'h1, 2'h2} || (ovr_src == 2'h3 && enumerated)) |=> !ovr_rejected &&
      pin_func[(int'($past(ovr_pin)) - 3) * 6 +: 6] == $past(ovr_func)) else $error("override lost");
  refuse_override_a:
    assert property (ovr_wr && (ovr_pin < 5'h03 || ovr_src == 2'h0 || (ovr_src == 2'h3 && !enumerated))
      |=> ovr_rejected) else $error("bad override taken");
endmodule : strap_mux_monitor
bind strap_latch_and_pin_function_mux strap_mux_monitor mon (.*);

//--- sim/test_strap_latch_and_pin_function_mux.sv
// Self-checking bench for the strap latch and pin mux.
// Assumes the board model supplies the map and port count straps; the bench drives the line-disable straps.
`timescale 1ns/1ps
`include "strap_mux_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_strap_latch_and_pin_function_mux;
  logic clk = 1'b0, arst_n = 1'b0, chip_reset_n = 1'b0, cfg_two = 1'b0, ovr_wr = 1'b0, enumerated = 1'b0;
  logic valid, cfg2_o, resv, rej;
  logic [1:0] ovr_src = 2'h0;
  logic [2:0] fixed_lvl = 3'h0, chg_lvl = 3'h0, fps, cps, ms1, ms2, ms3;
  logic [4:0] ovr_pin = 5'h03;
  logic [5:0] dis_p = 6'h00, dis_m = 6'h00, ovr_func = 6'h00, pld, mld, pdis, ssd, pfix, dcp, cdp;
  logic [173:0] pin_func;
  logic [5:0] masks[6] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h3F};
  int pins[14] = '{3, 5, 7, 10, 11, 18, 19, 20, 25, 26, 27, 28, 29, 31};
  int mismatches = 0, n_tests = 0;
  // Free running clock
  always #5 clk = ~clk;
  strap_board board (.cfg_two(cfg_two), .fixed_lvl(fixed_lvl), .chg_lvl(chg_lvl), .map_strap_1(ms1),
    .map_strap_2(ms2), .map_strap_3(ms3), .fixed_port_count_strap(fps), .charging_port_count_strap(cps));
  strap_latch_and_pin_function_mux uut (.clk(clk), .arst_n(arst_n), .chip_reset_n(chip_reset_n),
    .port_plus_line_disable_strap(dis_p), .port_minus_line_disable_strap(dis_m), .fixed_port_count_strap(fps),
    .charging_port_count_strap(cps), .map_strap_1(ms1), .map_strap_2(ms2), .ovr_wr(ovr_wr), .ovr_src(ovr_src),
    .ovr_pin(ovr_pin), .ovr_func(ovr_func), .enumerated(enumerated), .straps_valid(valid),
    .plus_line_disabled(pld), .minus_line_disabled(mld), .port_disabled(pdis), .superspeed_disabled(ssd),
    .port_fixed(pfix), .dcp_enable(dcp), .cdp_enable(cdp), .map_config_two(cfg2_o), .map_reserved(resv),
    .ovr_rejected(rej), .pin_func(pin_func));
  // Expected default function per pin
  function automatic logic [5:0] exp_func(input logic c2, input int p);
    case (p)
      3: return `FN_CONN_SUPPLY_SWITCH_B;
      5: return `FN_PORT_DISCHARGE_CONTROL;
      7: return c2 ? `FN_MICROPHONE_DETECT : `FN_GENERAL_IO_71;
      10: return c2 ? `FN_AUDIO_SERIAL_IN : `FN_PORT2_POWER_CTL_SUPERSPEED;
      11: return c2 ? `FN_AUDIO_MASTER_CLOCK : `FN_PORT3_POWER_CTL_SUPERSPEED;
      18: return `FN_ALERT_INPUT_ZERO;
      19: return c2 ? `FN_AUDIO_SERIAL_OUT : `FN_NONE;
      20: return `FN_FLASH_SELECT_N;
      25: return `FN_FLASH_DATA3;
      26: return c2 ? `FN_AUDIO_BIT_CLOCK : `FN_TWOWIRE_TARGET_CLOCK;
      27: return c2 ? `FN_PORT6_POWER_CTL : `FN_TWOWIRE_TARGET_DATA;
      28: return c2 ? `FN_AUDIO_WORD_SELECT : `FN_PORT6_POWER_CTL;
      31: return `FN_TWOWIRE_BRIDGE_DATA;
      default: return `FN_NONE;
    endcase
  endfunction : exp_func
  // Straps change only while chip reset is held, so capture is clean
  task automatic strap_reset(input int lvl);
    @(posedge clk);
    #1;
    chip_reset_n = 0;
    cfg_two = lvl[0];
    fixed_lvl = 3'(lvl);
    chg_lvl = 3'(5 - lvl);
    dis_p = 6'h35 ^ 6'(lvl);
    dis_m = 6'h1E;
    repeat (3) @(posedge clk);
    #1;
    chip_reset_n = 1;
    repeat (3) @(posedge clk);
    #1;
  endtask : strap_reset
  task automatic t_levels;
    logic [5:0] keep;
    for (int l = 0; l < 6; l++)
    begin
      strap_reset(l);
      `CHK("valid", 1'b1, valid)
      `CHK("plus", dis_p, pld)
      `CHK("minus", dis_m, mld)
      `CHK("disabled", dis_p & dis_m, pdis)
      `CHK("superspeed", dis_p & dis_m, ssd)
      `CHK("fixed", masks[l], pfix)
      `CHK("dcp", masks[5 - l], dcp)
      `CHK("cdp", masks[5 - l], cdp)
      `CHK("map", cfg_two, cfg2_o)
      `CHK("reserved", 1'b0, resv)
      `CHK("spare strap", `LVL_WEAK_DOWN, ms3)
      foreach (pins[i]) `CHK("pin", exp_func(cfg_two, pins[i]), pin_func[(pins[i] - 3) * 6 +: 6])
      keep = dis_p;
      dis_p = ~dis_p;
      fixed_lvl = 3'h5 - fixed_lvl;
      repeat (3) @(posedge clk);
      #1;
      `CHK("frozen", keep, pld)
      `CHK("frozen fixed", masks[l], pfix)
    end
    $display("test levels done");
  endtask : t_levels
  // One override write; strobe stays up so writes run back to back
  task automatic wr(input logic [1:0] s, input logic [4:0] p, input logic [5:0] f, input logic bad);
    logic [5:0] old;
    old = pin_func[(int'(p) - 3) * 6 +: 6];
    ovr_wr = 1;
    ovr_src = s;
    ovr_pin = p;
    ovr_func = f;
    @(posedge clk);
    #1;
    `CHK("rejected", bad, rej)
    if (p >= 5'h03)
      `CHK("field", bad ? old : f, pin_func[(int'(p) - 3) * 6 +: 6])
  endtask : wr
  task automatic t_override;
    wr(2'h1, 5'h03, `FN_GENERAL_IO_70, 1'b0);
    wr(2'h2, 5'h1F, `FN_AUDIO_SERIAL_OUT, 1'b0);
    wr(2'h3, 5'h1D, `FN_ALERT_INPUT_ZERO, 1'b1);
    enumerated = 1;
    wr(2'h3, 5'h1D, `FN_ALERT_INPUT_ZERO, 1'b0);
    wr(2'h0, 5'h07, `FN_FLASH_CLOCK, 1'b1);
    wr(2'h1, 5'h02, `FN_FLASH_CLOCK, 1'b1);
    ovr_wr = 0;
    // Chip reset drops the latch, so writes are refused and defaults come back
    chip_reset_n = 0;
    @(posedge clk);
    #1;
    wr(2'h1, 5'h04, `FN_FLASH_CLOCK, 1'b1);
    ovr_wr = 0;
    chip_reset_n = 1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("reload", exp_func(cfg_two, 3), pin_func[5:0])
    $display("test override done");
  endtask : t_override
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1;
    t_levels();
    t_override();
    print_verdict();
  end
  // Watchdog, about seven times the expected run
  initial
  begin
    #5000;
    mismatches++;
    print_verdict();
  end
endmodule : test_strap_latch_and_pin_function_mux
